// [cfglc_pkg.sv]
// Package: register map, field positions and function codes of the configurable logic cell
package cfglc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // Register offsets (word index on the register port)
  localparam logic [ADDR_W-1:0] OFF_CTRL_LO  = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL_HI  = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_SRC_SEL  = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_GATE_LO  = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_GATE_HI  = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h5;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h6;

  localparam logic [DATA_W-1:0] RST_REG = 16'h0000;

  // Writable bits per register; all other bits read as zero, except the output status bit of control low
  localparam logic [DATA_W-1:0] CTRL_LO_WMASK = 16'h8CA7;
  localparam logic [DATA_W-1:0] CTRL_HI_WMASK = 16'h000F;
  localparam logic [DATA_W-1:0] SRC_SEL_WMASK = 16'h7777;
  localparam logic [DATA_W-1:0] IRQ_WMASK     = 16'h0003;

  // Control low fields
  localparam int BIT_ENABLE   = 15;
  localparam int BIT_RISE_IRQ = 11;
  localparam int BIT_FALL_IRQ = 10;
  localparam int BIT_PIN_OE   = 7;
  localparam int BIT_OUT_STAT = 6;
  localparam int BIT_OUT_INV  = 5;
  localparam int FUNC_LSB     = 0;
  localparam int FUNC_W       = 3;

  // Interrupt status / mask fields
  localparam int IRQ_RISE = 0;
  localparam int IRQ_FALL = 1;
  localparam int IRQ_W    = 2;

  // Mux select fields are 3 bits on a 4-bit pitch, gate enables one byte per gate
  localparam int SEL_W     = 3;
  localparam int SEL_PITCH = 4;
  localparam int GATE_W    = 8;

  // Source codes with a fixed meaning
  localparam logic [SEL_W-1:0] SRC_CELL_OUT  = 3'h1;
  localparam logic [SEL_W-1:0] SRC_SERIAL_SP = 3'h3;
  localparam logic [SEL_W-1:0] SRC_SERIAL_RX = 3'h4;
  localparam logic [SEL_W-1:0] SRC_UNUSED    = 3'h5;
  localparam logic [SEL_W-1:0] SRC_CMP2      = 3'h6;
  localparam logic [SEL_W-1:0] SRC_CMP3      = 3'h7;

  localparam int NO_SPI_INST = 4;

  typedef enum logic [FUNC_W-1:0] {
    FN_AND_OR, FN_OR_XOR, FN_AND4, FN_SR_LATCH,
    FN_DFF1_SR, FN_DFF2_R, FN_JK_R, FN_LATCH_SR
  } cfglc_func_t;

endpackage : cfglc_pkg

// [cfglc_cell.sv]
// Configurable logic cell: source muxes, input gates, logic function, output and edge interrupts
`timescale 1ns/10ps

module cfglc_cell
  import cfglc_pkg::*;
#(
  parameter int INST = 1
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic [7:0]        mux1Src,
  input  wire logic [7:0]        mux2Src,
  input  wire logic [7:0]        mux3Src,
  input  wire logic [7:0]        mux4Src,
  input  wire logic              pairOut,
  input  wire logic              serialRx,
  input  wire logic              serialTx,
  input  wire logic              spiDataIn,
  input  wire logic              spiDataOut,
  input  wire logic              compare2Flag,
  input  wire logic              compare3Flag,
  output logic                   cellOut,
  output logic                   pinOut,
  output logic                   pinOe,
  output logic                   irq
);

  localparam int EXT_W = 38;

  logic [DATA_W-1:0] ctrlLo_ff;
  logic [DATA_W-1:0] ctrlHi_ff;
  logic [DATA_W-1:0] srcSel_ff;
  logic [DATA_W-1:0] gateLo_ff;
  logic [DATA_W-1:0] gateHi_ff;
  logic [IRQ_W-1:0]  irqStat_ff;
  logic [IRQ_W-1:0]  irqMask_ff;
  logic [EXT_W-1:0]  sync1_ff;
  logic [EXT_W-1:0]  sync2_ff;
  logic              seq_ff;
  logic              gClkPrev_ff;
  logic              cellOut_ff;
  logic              pinOut_ff;
  logic              pinOe_ff;
  logic              irq_ff;
  logic [DATA_W-1:0] regRdata_ff;

  logic [7:0]        s1;
  logic [7:0]        s2;
  logic [7:0]        s3;
  logic [7:0]        s4;
  logic [3:0]        dsrc;
  logic [3:0]        gate;
  logic              cellEn;
  cfglc_func_t       func;
  logic              funcOut;
  logic              nxt_seq;
  logic              nxt_cellOut;
  logic              gClkRise;
  logic              riseEv;
  logic              fallEv;
  logic              wrStat;
  logic [DATA_W-1:0] nxt_rdata;

  function automatic logic [SEL_W-1:0] muxSel(input logic [DATA_W-1:0] r, input int n);
    muxSel = r[n*SEL_PITCH +: SEL_W];
  endfunction : muxSel

  // Byte order: src4 true, src4 inverted, ... src1 true, src1 inverted
  function automatic logic gateOr(input logic [GATE_W-1:0] en, input logic [3:0] d);
    logic [GATE_W-1:0] cand;
    cand = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
    gateOr = |(en & cand);
  endfunction : gateOr

  // External sources except pairOut cross into mclk through two flops; only the second is read
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {mux1Src, mux2Src, mux3Src, mux4Src, serialRx, serialTx,
                   spiDataIn, spiDataOut, compare2Flag, compare3Flag};
      sync2_ff <= sync1_ff;
    end
  end

  assign s1 = sync2_ff[37:30];
  assign s2 = sync2_ff[29:22];
  assign s3 = sync2_ff[21:14];
  assign s4 = sync2_ff[13:6];

  // Source muxes with the cell-specific slots overriding the generic inputs
  always_comb begin
    dsrc[0] = s1[muxSel(srcSel_ff, 0)];
    dsrc[1] = s2[muxSel(srcSel_ff, 1)];
    dsrc[2] = s3[muxSel(srcSel_ff, 2)];
    dsrc[3] = s4[muxSel(srcSel_ff, 3)];
    if (muxSel(srcSel_ff, 0) == SRC_UNUSED) dsrc[0] = 1'b0;
    case (muxSel(srcSel_ff, 1))
      SRC_CELL_OUT:  dsrc[1] = pairOut;
      SRC_SERIAL_SP: dsrc[1] = sync2_ff[4];
      default: ;
    endcase
    case (muxSel(srcSel_ff, 2))
      SRC_CELL_OUT:  dsrc[2] = cellOut_ff;
      SRC_SERIAL_SP: dsrc[2] = (INST == NO_SPI_INST) ? 1'b0 : sync2_ff[2];
      SRC_SERIAL_RX: dsrc[2] = sync2_ff[5];
      SRC_CMP2:      dsrc[2] = sync2_ff[1];
      SRC_CMP3:      dsrc[2] = sync2_ff[0];
      default: ;
    endcase
    case (muxSel(srcSel_ff, 3))
      SRC_CELL_OUT:  dsrc[3] = pairOut;
      SRC_SERIAL_SP: dsrc[3] = (INST == NO_SPI_INST) ? 1'b0 : sync2_ff[3];
      SRC_UNUSED:    dsrc[3] = 1'b0;
      default: ;
    endcase
  end

  // Input gates and their polarity
  assign gate[0] = gateOr(gateLo_ff[0 +: GATE_W], dsrc) ^ ctrlHi_ff[0];
  assign gate[1] = gateOr(gateLo_ff[GATE_W +: GATE_W], dsrc) ^ ctrlHi_ff[1];
  assign gate[2] = gateOr(gateHi_ff[0 +: GATE_W], dsrc) ^ ctrlHi_ff[2];
  assign gate[3] = gateOr(gateHi_ff[GATE_W +: GATE_W], dsrc) ^ ctrlHi_ff[3];

  assign cellEn   = ctrlLo_ff[BIT_ENABLE];
  assign func     = cfglc_func_t'(ctrlLo_ff[FUNC_LSB +: FUNC_W]);
  assign gClkRise = gate[0] & ~gClkPrev_ff;

  // Storage modes: gate 1 is the clock/enable and reset and set are level inputs with reset first, except the SR latch, where gates 1 and 2 set and set wins.
  // Edges are sampled on mclk, so a gate clock pulse shorter than one cycle is missed.
  always_comb begin
    nxt_seq = seq_ff;
    case (func)
      FN_SR_LATCH: begin
        if (gate[0] | gate[1]) nxt_seq = 1'b1;
        else if (gate[2] | gate[3]) nxt_seq = 1'b0;
      end
      FN_DFF1_SR: begin
        if (gate[2]) nxt_seq = 1'b0;
        else if (gate[3]) nxt_seq = 1'b1;
        else if (gClkRise) nxt_seq = gate[1];
      end
      FN_DFF2_R: begin
        if (gate[2]) nxt_seq = 1'b0;
        else if (gClkRise) nxt_seq = gate[1] & gate[3];
      end
      FN_JK_R: begin
        if (gate[2]) nxt_seq = 1'b0;
        else if (gClkRise) nxt_seq = (gate[1] & ~seq_ff) | (~gate[3] & seq_ff);
      end
      FN_LATCH_SR: begin
        if (gate[2]) nxt_seq = 1'b0;
        else if (gate[3]) nxt_seq = 1'b1;
        else if (gate[0]) nxt_seq = gate[1];
      end
      default: ;
    endcase
  end

  always_comb begin
    case (func)
      FN_AND_OR: funcOut = (gate[0] & gate[1]) | (gate[2] & gate[3]);
      FN_OR_XOR: funcOut = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
      FN_AND4:   funcOut = &gate;
      default:   funcOut = nxt_seq;
    endcase
  end

  assign nxt_cellOut = cellEn & (funcOut ^ ctrlLo_ff[BIT_OUT_INV]);

  // Storage is cleared while disabled so re-enabling starts from a known state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seq_ff      <= 1'b0;
      gClkPrev_ff <= 1'b0;
    end else begin
      seq_ff      <= cellEn & nxt_seq;
      gClkPrev_ff <= gate[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cellOut_ff <= 1'b0;
      pinOut_ff  <= 1'b0;
      pinOe_ff   <= 1'b0;
    end else begin
      cellOut_ff <= nxt_cellOut;
      pinOut_ff  <= nxt_cellOut;
      pinOe_ff   <= cellEn & ctrlLo_ff[BIT_PIN_OE];
    end
  end

  // Edge events taken at the cycle the output changes
  assign riseEv = cellEn & ctrlLo_ff[BIT_RISE_IRQ] & nxt_cellOut & ~cellOut_ff;
  assign fallEv = cellEn & ctrlLo_ff[BIT_FALL_IRQ] & ~nxt_cellOut & cellOut_ff;
  assign wrStat = regWr && (regAddr == OFF_IRQ_STAT);

  // Write-one-to-clear; a new event in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irqStat_ff <= '0;
    end else begin
      irqStat_ff[IRQ_RISE] <= riseEv | (irqStat_ff[IRQ_RISE] & ~(wrStat & regWdata[IRQ_RISE]));
      irqStat_ff[IRQ_FALL] <= fallEv | (irqStat_ff[IRQ_FALL] & ~(wrStat & regWdata[IRQ_FALL]));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irqStat_ff & irqMask_ff);
    end
  end

  // Configuration registers; the status bit is masked out of writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrlLo_ff  <= RST_REG;
      ctrlHi_ff  <= RST_REG;
      srcSel_ff  <= RST_REG;
      gateLo_ff  <= RST_REG;
      gateHi_ff  <= RST_REG;
      irqMask_ff <= '0;
    end else if (regWr) begin
      case (regAddr)
        OFF_CTRL_LO:  ctrlLo_ff  <= regWdata & CTRL_LO_WMASK;
        OFF_CTRL_HI:  ctrlHi_ff  <= regWdata & CTRL_HI_WMASK;
        OFF_SRC_SEL:  srcSel_ff  <= regWdata & SRC_SEL_WMASK;
        OFF_GATE_LO:  gateLo_ff  <= regWdata;
        OFF_GATE_HI:  gateHi_ff  <= regWdata;
        OFF_IRQ_MASK: irqMask_ff <= regWdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_rdata = '0;
    if (regRd) begin
      case (regAddr)
        OFF_CTRL_LO: begin
          nxt_rdata               = ctrlLo_ff;
          nxt_rdata[BIT_OUT_STAT] = cellOut_ff;
        end
        OFF_CTRL_HI:  nxt_rdata = ctrlHi_ff;
        OFF_SRC_SEL:  nxt_rdata = srcSel_ff;
        OFF_GATE_LO:  nxt_rdata = gateLo_ff;
        OFF_GATE_HI:  nxt_rdata = gateHi_ff;
        OFF_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = irqStat_ff;
        OFF_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = irqMask_ff;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      regRdata_ff <= '0;
    end else begin
      regRdata_ff <= nxt_rdata;
    end
  end

  assign regRdata = regRdata_ff;
  assign cellOut  = cellOut_ff;
  assign pinOut   = pinOut_ff;
  assign pinOe    = pinOe_ff;
  assign irq      = irq_ff;

  a_disabled_out_low: assert property (@(posedge mclk) disable iff (!rst_n)
    !cellEn |=> !cellOut)
    else $error("cell output high while disabled");

  a_pin_drive_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrlLo_ff[BIT_PIN_OE] |=> !pinOe && (pinOut == cellOut))
    else $error("pin driven with drive enable clear");

  // A masked-in flag must reach irq; a fall flag may hold irq high on its own
  a_rise_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (cellEn && ctrlLo_ff[BIT_RISE_IRQ] && nxt_cellOut && !cellOut_ff)
      |=> irqStat_ff[IRQ_RISE] ##1 (!$past(irqMask_ff[IRQ_RISE]) || irq))
    else $error("rising edge did not set its flag");

  a_fall_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (cellEn && ctrlLo_ff[BIT_FALL_IRQ] && !nxt_cellOut && cellOut_ff) |=> irqStat_ff[IRQ_FALL])
    else $error("falling edge did not set its flag");

  a_pin_drive_on: assert property (@(posedge mclk) disable iff (!rst_n)
    (cellEn && ctrlLo_ff[BIT_PIN_OE]) |=> pinOe)
    else $error("pin not driven with drive enable set");

  a_fall_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
    (!ctrlLo_ff[BIT_FALL_IRQ] && !irqStat_ff[IRQ_FALL]) |=> !irqStat_ff[IRQ_FALL])
    else $error("falling flag set with its enable clear");

  a_and4_function: assert property (@(posedge mclk) disable iff (!rst_n)
    (cellEn && func == FN_AND4) |=> cellOut == ($past(&gate) ^ $past(ctrlLo_ff[BIT_OUT_INV])))
    else $error("four-input AND output wrong");

  a_dff2_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    (cellEn && func == FN_DFF2_R && !gate[2] && gClkRise)
      |=> cellOut == ($past(gate[1] & gate[3]) ^ $past(ctrlLo_ff[BIT_OUT_INV])))
    else $error("two-input D flop did not capture");

  a_gate_empty_or: assert property (@(posedge mclk) disable iff (!rst_n)
    (gateLo_ff[0 +: GATE_W] == 8'h00) |-> (gate[0] == ctrlHi_ff[0]))
    else $error("gate 1 active with no source enabled");

  a_mux3_own_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (muxSel(srcSel_ff, 2) == SRC_CELL_OUT) |-> (dsrc[2] == cellOut_ff))
    else $error("mux 3 does not return the cell output");

  a_status_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    (regRd && regAddr == OFF_CTRL_LO) |=> (regRdata[BIT_OUT_STAT] == $past(cellOut_ff))
      ##1 (regRdata == 16'h0000 || $past(regRd)))
    else $error("output status bit does not track output");

endmodule : cfglc_cell

// [cfglc_periph_model.sv]
// Behavioural model of the peripheral event lines and the output pin around the cell
`timescale 1ns/10ps
module cfglc_periph_model (
  input  wire logic       mclk,
  input  wire logic [6:0] evtIn,
  input  wire logic       pinOut,
  input  wire logic       pinOe,
  output logic            pairOut,
  output logic            serialRx,
  output logic            serialTx,
  output logic            spiDataIn,
  output logic            spiDataOut,
  output logic            compare2Flag,
  output logic            compare3Flag,
  output logic            pinLevel
);
  logic [6:0] evt_ff = 7'h00;

  // Producers change just after the edge, as on-chip peripherals do
  always @(posedge mclk) begin
    evt_ff <= evtIn;
  end
  assign {compare3Flag, compare2Flag, spiDataOut, spiDataIn, serialTx, serialRx, pairOut} = evt_ff;
  // Pull-down on the pin: a released pin reads low, never the last driven level
  assign pinLevel = pinOe ? pinOut : 1'b0;
endmodule : cfglc_periph_model

// [cfglc_tb.sv]
// Self-checking testbench of the configurable logic cell
`timescale 1ns/10ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %0t got %h exp %h", $time, got, exp); end end
module tb;
  import cfglc_pkg::*;
  logic              mclk     = 1'b0;
  logic              rst_n    = 1'b0;
  logic [ADDR_W-1:0] regAddr  = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic              regWr    = 1'b0;
  logic              regRd    = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic [7:0]        src [4]  = '{default: 8'h00};
  logic [6:0]        evt      = 7'h00;
  logic              pairOut, serialRx, serialTx, spiDataIn, spiDataOut, compare2Flag, compare3Flag;
  logic              cellOut, pinOut, pinOe, irq, pinLevel;
  int                errors   = 0;
  int                nTests   = 0;

  always #4 mclk = ~mclk;

  cfglc_cell u_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .mux1Src(src[0]), .mux2Src(src[1]), .mux3Src(src[2]), .mux4Src(src[3]),
    .pairOut(pairOut), .serialRx(serialRx), .serialTx(serialTx), .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
    .compare2Flag(compare2Flag), .compare3Flag(compare3Flag), .cellOut(cellOut), .pinOut(pinOut), .pinOe(pinOe),
    .irq(irq));

  cfglc_periph_model u_model (.mclk(mclk), .evtIn(evt), .pinOut(pinOut), .pinOe(pinOe), .pairOut(pairOut),
    .serialRx(serialRx), .serialTx(serialTx), .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
    .compare2Flag(compare2Flag), .compare3Flag(compare3Flag), .pinLevel(pinLevel));

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge
  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1;
    `CHK(regRdata, exp)
  endtask : rdChk

  // Two sync flops, output flop and the model's own register
  task automatic settle;
    repeat (5) @(posedge mclk);
    #1;
  endtask : settle

  // Inverse pattern on unselected codes catches a wrong mux pick
  task automatic drive(input logic [3:0] v);
    @(posedge mclk);
    for (int n = 0; n < 4; n++) src[n] <= v[n] ? 8'h01 : 8'hFE;
    settle;
  endtask : drive

  task automatic tReset;
    for (int a = 0; a < 8; a++) rdChk(a[2:0], 16'h0000);
    $display("done reset values");
  endtask : tReset

  task automatic tRegs;
    logic [DATA_W-1:0] expR [8];
    expR = '{16'h0CA7, 16'h000F, 16'h7777, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0003, 16'h0000};
    for (int a = 1; a < 8; a++) wr(a[2:0], 16'hFFFF);
    wr(OFF_CTRL_LO, 16'h7FFF);
    for (int a = 0; a < 8; a++) rdChk(a[2:0], expR[a]);
    for (int a = 0; a < 7; a++) wr(a[2:0], 16'h0000);
    $display("done register access");
  endtask : tRegs

  task automatic tComb;
    logic [3:0] g;
    logic       e;
    wr(OFF_GATE_LO, 16'h0802);
    wr(OFF_GATE_HI, 16'h8020);
    for (int f = 0; f < 3; f++) for (int p = 0; p < 2; p++) begin
      wr(OFF_CTRL_HI, p ? 16'h000A : 16'h0000);
      wr(OFF_CTRL_LO, 16'h8080 | 16'(p << 5) | 16'(f));
      for (int v = 0; v < 16; v++) begin
        drive(v[3:0]);
        g = v[3:0] ^ (p ? 4'hA : 4'h0);
        case (f)
          0: e = (g[0] & g[1]) | (g[2] & g[3]);
          1: e = (g[0] | g[1]) ^ (g[2] | g[3]);
          default: e = &g;
        endcase
        e = e ^ p[0];
        `CHK(cellOut, e)
        `CHK(pinOut, e)
      end
    end
    `CHK(pinOe, 1'b1)
    rdChk(OFF_CTRL_LO, 16'h80E2);
    $display("done combinational functions");
  endtask : tComb

  task automatic tSeq;
    logic [19:0] stp [5];
    logic [4:0]  ex [5];
    logic [2:0]  fn [5];
    stp = '{20'hC4032, 20'h50401, 20'h23213, 20'h32B4B, 20'hBAB43};
    ex  = '{5'b00110, 5'b10011, 5'b11001, 5'b01101, 5'b01101};
    fn  = '{3'h4, 3'h3, 3'h7, 3'h5, 3'h6};
    wr(OFF_CTRL_HI, 16'h0000);
    for (int m = 0; m < 5; m++) begin
      wr(OFF_CTRL_LO, 16'h0000);
      drive(4'h0);
      wr(OFF_CTRL_LO, 16'h8000 | 16'(fn[m]));
      for (int s = 0; s < 5; s++) begin
        drive(stp[m][4*s +: 4]);
        `CHK(cellOut, ex[m][s])
      end
    end
    $display("done latches and flip-flops");
  endtask : tSeq

  task automatic tIrq;
    wr(OFF_CTRL_LO, 16'h0000);
    wr(OFF_GATE_LO, 16'h0002);
    wr(OFF_GATE_HI, 16'h0000);
    wr(OFF_CTRL_HI, 16'h000E);
    drive(4'h0);
    wr(OFF_IRQ_MASK, 16'h0003);
    wr(OFF_CTRL_LO, 16'h8802);
    drive(4'h1);
    `CHK(cellOut, 1'b1)
    `CHK(pinOe, 1'b0)
    `CHK(pinLevel, 1'b0)
    `CHK(irq, 1'b1)
    drive(4'h0);
    rdChk(OFF_IRQ_STAT, 16'h0001);
    wr(OFF_IRQ_STAT, 16'h0001);
    settle;
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_MASK, 16'h0000);
    wr(OFF_CTRL_LO, 16'h8402);
    drive(4'h1);
    drive(4'h0);
    rdChk(OFF_IRQ_STAT, 16'h0002);
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_STAT, 16'h0002);
    wr(OFF_CTRL_LO, 16'h8C82);
    drive(4'h1);
    wr(OFF_IRQ_STAT, 16'h0001);
    wr(OFF_CTRL_LO, 16'h0C82);
    settle;
    `CHK(cellOut, 1'b0)
    `CHK(pinOe, 1'b0)
    rdChk(OFF_IRQ_STAT, 16'h0000);
    rdChk(OFF_CTRL_HI, 16'h000E);
    $display("done interrupts and disable");
  endtask : tIrq

  task automatic tRoute;
    logic [11:0] rt [8];
    logic [6:0]  hot;
    rt = '{12'h210, 12'h410, 12'h341, 12'h232, 12'h433, 12'h334, 12'h365, 12'h376};
    wr(OFF_CTRL_LO, 16'h8002);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_SRC_SEL, 16'(rt[i][6:4]) << (4 * (rt[i][11:8] - 1)));
      wr(OFF_GATE_LO, 16'h0002 << (2 * (rt[i][11:8] - 1)));
      for (int lv = 0; lv < 2; lv++) begin
        hot = 7'h01 << rt[i][2:0];
        @(posedge mclk);
        evt <= lv ? hot : ~hot;
        for (int n = 0; n < 4; n++) src[n] <= lv ? 8'h00 : 8'hFF;
        settle;
        `CHK(cellOut, lv[0])
      end
    end
    // Unused codes on mux 1 and 4 must read low even with the generic slot high
    wr(OFF_SRC_SEL, 16'h5005);
    wr(OFF_GATE_LO, 16'h0082);
    drive(4'h0);
    `CHK(cellOut, 1'b0)
    // Own output inverted back into gate 1 makes the cell toggle every cycle
    wr(OFF_SRC_SEL, 16'h0100);
    wr(OFF_GATE_LO, 16'h0010);
    settle;
    hot[0] = cellOut;
    @(posedge mclk);
    #1;
    `CHK(cellOut, ~hot[0])
    $display("done source routing");
  endtask : tRoute

  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stopTest

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    tReset;
    tRegs;
    tComb;
    tSeq;
    tIrq;
    tRoute;
    stopTest;
  end

  // Watchdog against a hung run
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    stopTest;
  end
endmodule : tb
